// ### hdl/fcs_sequencer.sv
// flash command sequencer with status and security registers on avalon-mm
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module fcs_sequencer #(
  parameter logic [31:0] ID_CODE = 32'h0000_5a5a // arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [16:0] arrayRdAddr,
  input  wire logic [31:0] arrayRdData,
  input  wire logic [3:0]  blockProtect,
  output logic             opStart,
  output logic      [1:0]  opKind,
  output logic      [16:0] opAddr,
  output logic      [3:0]  eraseMask,
  output logic             pgmWordValid,
  output logic      [16:0] pgmWordAddr,
  output logic      [31:0] pgmWordData,
  input  wire logic        opDone,
  input  wire logic        opFail,
  output logic             readMode,
  output logic             idMode,
  output logic             securityEnable,
  output logic             arraySettled
);
  localparam int AW = fcs_pkg::FLASH_AW;
  localparam int SETTLE_W = fcs_pkg::SETTLE_W;

  logic                 waitReq_reg;
  logic                 phase_reg;
  logic [31:0]          readData_reg;
  logic [AW-1:0]        arrayRdAddr_reg;
  fcs_pkg::fcs_state_e  state_reg;
  fcs_pkg::fcs_state_e  state_next;
  logic [9:0]           pageBase_reg;
  logic [4:0]           wordCnt_reg;
  logic                 rdy_reg;
  logic                 failed_reg;
  logic                 opStart_reg;
  fcs_pkg::fcs_op_e     opKind_reg;
  logic [AW-1:0]        opAddr_reg;
  logic [3:0]           eraseMask_reg;
  logic                 pgmValid_reg;
  logic [AW-1:0]        pgmAddr_reg;
  logic [31:0]          pgmData_reg;
  logic                 readMode_reg;
  logic                 idMode_reg;
  logic [11:0]          settleCnt_reg;
  logic                 settled_reg;
  logic                 secEnable;

  logic                 reqFresh;
  logic                 reqTaken;
  logic                 fullWord;
  logic                 hitFlash;
  logic                 hitRegs;
  logic [7:0]           regOfs;
  logic                 cmdWr;
  logic                 lockKeyWr;
  logic                 lockDataWr;
  logic [7:0]           cmdAdr;
  logic [7:0]           cmdData;
  logic [1:0]           blkSel;
  logic                 blkProt;
  logic                 secureLock;
  logic                 pageWordOk;
  logic                 startOp;
  fcs_pkg::fcs_op_e     startKind;
  logic [31:0]          readNext;

  // address decode and request phases
  assign reqFresh   = (avs_read | avs_write) & waitReq_reg;
  assign reqTaken   = (avs_read | avs_write) & ~waitReq_reg;
  assign fullWord   = (avs_byteenable == fcs_pkg::BE_FULL);
  assign hitFlash   = ((avs_address & fcs_pkg::FLASH_MASK) == fcs_pkg::FLASH_BASE);
  assign hitRegs    = ((avs_address & fcs_pkg::REG_PAGE_MASK) == fcs_pkg::REG_BASE);
  assign regOfs     = avs_address[fcs_pkg::OFS_W-1:0];
  assign cmdAdr     = avs_address[fcs_pkg::CMD_FLD_LSB +: fcs_pkg::CMD_FLD_W];
  assign cmdData    = avs_writedata[fcs_pkg::DATA_W-1:0];
  assign blkSel     = avs_address[fcs_pkg::BLK_LSB +: fcs_pkg::BLK_W];
  assign blkProt    = blockProtect[blkSel];

  // strobes act only on the edge where the request completes
  assign cmdWr      = reqTaken & avs_write & hitFlash & fullWord;
  assign lockKeyWr  = reqTaken & avs_write & hitRegs & fullWord &
                      (regOfs == fcs_pkg::OFS_LOCK) & (avs_writedata == fcs_pkg::LOCK_KEY);
  assign lockDataWr = reqTaken & avs_write & hitRegs & fullWord &
                      (regOfs == fcs_pkg::OFS_LOCK) & (avs_writedata != fcs_pkg::LOCK_KEY);

  // security is active only with the bit set and every block protected
  assign secureLock = secEnable & (&blockProtect);

  // page words must arrive in ascending order from the page start
  always_comb begin
    if (wordCnt_reg == 5'h0) begin
      pageWordOk = (avs_address[fcs_pkg::PAGE_LSB-1:fcs_pkg::WORD_LSB] == 5'h0) & ~blkProt;
    end else begin
      pageWordOk = (avs_address[AW-1:fcs_pkg::WORD_LSB] == {pageBase_reg, wordCnt_reg});
    end
  end

  // two-cycle slave: phase one presents the array address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      waitReq_reg <= 1'b1;
      phase_reg   <= 1'b0;
    end else if (reqTaken) begin
      waitReq_reg <= 1'b1;
      phase_reg   <= 1'b0;
    end else if (reqFresh && phase_reg) begin
      waitReq_reg <= 1'b0;
    end else if (reqFresh) begin
      phase_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arrayRdAddr_reg <= '0;
    end else if (reqFresh && !phase_reg) begin
      arrayRdAddr_reg <= avs_address[AW-1:0];
    end
  end

  // status and lock live outside the array, so never blocked
  always_comb begin
    readNext = 32'h0;
    if (hitRegs && regOfs == fcs_pkg::OFS_STATUS) begin
      readNext[fcs_pkg::STAT_RDY_BIT] = rdy_reg;
      readNext[fcs_pkg::STAT_PROT_LSB +: fcs_pkg::NUM_BLOCKS] = blockProtect;
    end else if (hitRegs && regOfs == fcs_pkg::OFS_LOCK) begin
      readNext[fcs_pkg::LOCK_SEC_BIT] = secEnable;
    end else if (hitFlash && idMode_reg) begin
      readNext = ID_CODE;
    end else if (hitFlash && readMode_reg) begin
      readNext = arrayRdData;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      readData_reg <= 32'h0;
    end else if (reqFresh && phase_reg) begin
      readData_reg <= readNext;
    end
  end

  // command decoder; the f0 escape is not checked inside page data
  always_comb begin
    state_next = state_reg;
    startOp    = 1'b0;
    startKind  = fcs_pkg::OP_PAGE;
    case (state_reg)
      fcs_pkg::ST_BUSY: begin
        if (opDone && !opFail && !failed_reg) begin
          state_next = fcs_pkg::ST_READ;
        end
      end
      fcs_pkg::ST_PAGE: begin
        if (cmdWr && !pageWordOk) begin
          state_next = fcs_pkg::ST_READ;
        end else if (cmdWr && wordCnt_reg == fcs_pkg::LAST_WORD) begin
          state_next = fcs_pkg::ST_BUSY;
          startOp    = 1'b1;
          startKind  = fcs_pkg::OP_PAGE;
        end
      end
      default: begin
        if (cmdWr && cmdData == fcs_pkg::D_READ) begin
          state_next = fcs_pkg::ST_READ;
        end else if (cmdWr) begin
          case (state_reg)
            fcs_pkg::ST_READ: begin
              if (cmdAdr == fcs_pkg::ADR_55 && cmdData == fcs_pkg::D_UNLOCK1 && !secureLock) begin
                state_next = fcs_pkg::ST_C1;
              end
            end
            fcs_pkg::ST_C1: begin
              state_next = (cmdAdr == fcs_pkg::ADR_AA && cmdData == fcs_pkg::D_UNLOCK2) ?
                           fcs_pkg::ST_C2 : fcs_pkg::ST_READ;
            end
            fcs_pkg::ST_C2: begin
              if (cmdAdr != fcs_pkg::ADR_55) begin
                state_next = fcs_pkg::ST_READ;
              end else if (cmdData == fcs_pkg::D_PROGRAM) begin
                state_next = fcs_pkg::ST_PAGE;
              end else if (cmdData == fcs_pkg::D_ERASE) begin
                state_next = fcs_pkg::ST_E3;
              end else if (cmdData == fcs_pkg::D_IDREAD) begin
                state_next = fcs_pkg::ST_ID;
              end else begin
                state_next = fcs_pkg::ST_READ;
              end
            end
            fcs_pkg::ST_E3: begin
              state_next = (cmdAdr == fcs_pkg::ADR_55 && cmdData == fcs_pkg::D_UNLOCK1) ?
                           fcs_pkg::ST_E4 : fcs_pkg::ST_READ;
            end
            fcs_pkg::ST_E4: begin
              state_next = (cmdAdr == fcs_pkg::ADR_AA && cmdData == fcs_pkg::D_UNLOCK2) ?
                           fcs_pkg::ST_E5 : fcs_pkg::ST_READ;
            end
            fcs_pkg::ST_E5: begin
              state_next = fcs_pkg::ST_READ;
              if (cmdAdr == fcs_pkg::ADR_55 && cmdData == fcs_pkg::D_CHIP && !(&blockProtect)) begin
                state_next = fcs_pkg::ST_BUSY;
                startOp    = 1'b1;
                startKind  = fcs_pkg::OP_CHIP;
              end else if (cmdData == fcs_pkg::D_BLOCK && !blkProt) begin
                state_next = fcs_pkg::ST_BUSY;
                startOp    = 1'b1;
                startKind  = fcs_pkg::OP_BLOCK;
              end
            end
            default: begin
              state_next = state_reg; // identifier read holds until f0
            end
          endcase
        end
      end
    endcase
  end

  // state register; busy ignores all command writes until completion
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= fcs_pkg::ST_READ;
      readMode_reg <= 1'b1;
      idMode_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      readMode_reg <= (state_next == fcs_pkg::ST_READ);
      idMode_reg   <= (state_next == fcs_pkg::ST_ID);
    end
  end

  // page word tracking and forwarding to the array engine
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wordCnt_reg  <= 5'h0;
      pageBase_reg <= 10'h0;
      pgmValid_reg <= 1'b0;
      pgmAddr_reg  <= '0;
      pgmData_reg  <= 32'h0;
    end else begin
      pgmValid_reg <= 1'b0;
      if (state_reg != fcs_pkg::ST_PAGE) begin
        wordCnt_reg <= 5'h0;
      end else if (cmdWr && pageWordOk) begin
        if (wordCnt_reg == 5'h0) begin
          pageBase_reg <= avs_address[AW-1:fcs_pkg::PAGE_LSB];
        end
        wordCnt_reg  <= wordCnt_reg + 5'h1;
        pgmValid_reg <= 1'b1;
        pgmAddr_reg  <= avs_address[AW-1:0];
        pgmData_reg  <= avs_writedata;
      end
    end
  end

  // operation launch with erase mask that skips protected blocks
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      opStart_reg   <= 1'b0;
      opKind_reg    <= fcs_pkg::OP_PAGE;
      opAddr_reg    <= '0;
      eraseMask_reg <= 4'h0;
    end else begin
      opStart_reg <= startOp;
      if (startOp) begin
        opKind_reg <= startKind;
        case (startKind)
          fcs_pkg::OP_PAGE: begin
            opAddr_reg    <= {pageBase_reg, {fcs_pkg::PAGE_LSB{1'b0}}};
            eraseMask_reg <= 4'h0;
          end
          fcs_pkg::OP_CHIP: begin
            opAddr_reg    <= '0;
            eraseMask_reg <= ~blockProtect;
          end
          default: begin
            opAddr_reg    <= {blkSel, {fcs_pkg::BLK_LSB{1'b0}}};
            eraseMask_reg <= 4'h1 << blkSel;
          end
        endcase
      end
    end
  end

  // ready flag; a failure leaves it low until hardware reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_reg    <= 1'b1;
      failed_reg <= 1'b0;
    end else if (startOp) begin
      rdy_reg <= 1'b0;
    end else if (state_reg == fcs_pkg::ST_BUSY && opFail) begin
      failed_reg <= 1'b1;
    end else if (state_reg == fcs_pkg::ST_BUSY && opDone && !failed_reg) begin
      rdy_reg <= 1'b1;
    end
  end

  // settle timer only flags readiness; it does not block reads
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      settleCnt_reg <= 12'h0;
      settled_reg   <= 1'b1;
    end else if (startOp) begin
      settleCnt_reg <= 12'h0;
      settled_reg   <= 1'b0;
    end else if (state_reg == fcs_pkg::ST_BUSY && state_next == fcs_pkg::ST_READ) begin
      settleCnt_reg <= SETTLE_W'(fcs_pkg::SETTLE_CLKS);
    end else if (settleCnt_reg != 12'h0) begin
      settleCnt_reg <= settleCnt_reg - 12'h1;
      settled_reg   <= (settleCnt_reg == 12'h1);
    end
  end

  fcs_lock_window u_lock (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .keyWr     (lockKeyWr),
    .dataWr    (lockDataWr),
    .dataBit   (avs_writedata[fcs_pkg::LOCK_SEC_BIT]),
    .secEnable (secEnable)
  );

  assign avs_waitrequest = waitReq_reg;
  assign avs_readdata    = readData_reg;
  assign arrayRdAddr     = arrayRdAddr_reg;
  assign opStart         = opStart_reg;
  assign opKind          = opKind_reg;
  assign opAddr          = opAddr_reg;
  assign eraseMask       = eraseMask_reg;
  assign pgmWordValid    = pgmValid_reg;
  assign pgmWordAddr     = pgmAddr_reg;
  assign pgmWordData     = pgmData_reg;
  assign readMode        = readMode_reg;
  assign idMode          = idMode_reg;
  assign securityEnable  = secEnable;
  assign arraySettled    = settled_reg;
endmodule
`default_nettype wire

// ### include/fcs_pkg.sv
// constants, encodings and state codes shared by the flash command sequencer
package fcs_pkg;
  // register map
  localparam logic [31:0] REG_BASE      = 32'h41ff_f000;
  localparam logic [31:0] REG_PAGE_MASK = 32'hffff_ff00;
  localparam logic [7:0]  OFS_LOCK      = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h20;
  localparam int          OFS_W         = 8;
  // flash array window, 128 KB
  localparam int          FLASH_AW      = 17;
  localparam logic [31:0] FLASH_BASE    = 32'h0000_0000;
  localparam logic [31:0] FLASH_MASK    = 32'hfffe_0000;
  // register fields
  localparam int          STAT_RDY_BIT  = 0;
  localparam int          STAT_PROT_LSB = 16;
  localparam int          NUM_BLOCKS    = 4;
  localparam int          LOCK_SEC_BIT  = 0;
  localparam logic        SEC_RESET     = 1'b1;
  localparam logic [31:0] LOCK_KEY      = 32'ha74a_9d23;
  localparam logic [4:0]  LOCK_WIN_CLKS = 5'h10;
  localparam logic [3:0]  BE_FULL       = 4'hf;
  // command address and data fields
  localparam int          CMD_FLD_LSB   = 8;
  localparam int          CMD_FLD_W     = 8;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  ADR_55        = 8'h55;
  localparam logic [7:0]  ADR_AA        = 8'haa;
  localparam logic [7:0]  D_UNLOCK1     = 8'haa;
  localparam logic [7:0]  D_UNLOCK2     = 8'h55;
  localparam logic [7:0]  D_READ        = 8'hf0;
  localparam logic [7:0]  D_PROGRAM     = 8'ha0;
  localparam logic [7:0]  D_ERASE       = 8'h80;
  localparam logic [7:0]  D_IDREAD      = 8'h90;
  localparam logic [7:0]  D_CHIP        = 8'h10;
  localparam logic [7:0]  D_BLOCK       = 8'h30;
  // block and page geometry
  localparam int          BLK_LSB       = 15;
  localparam int          BLK_W         = 2;
  localparam int          PAGE_LSB      = 7;
  localparam int          WORD_LSB      = 2;
  localparam int          WCNT_W        = 5;
  localparam logic [4:0]  LAST_WORD     = 5'h1f;
  // settle time after ready rises
  localparam int          SETTLE_US     = 200;
  localparam int          CLK_KHZ       = 20000;
  localparam int          SETTLE_CLKS   = (SETTLE_US * CLK_KHZ + 999) / 1000;
  localparam int          SETTLE_W      = 12;

  typedef enum logic [1:0] {
    OP_PAGE  = 2'h0,
    OP_CHIP  = 2'h1,
    OP_BLOCK = 2'h2
  } fcs_op_e;

  typedef enum logic [8:0] {
    ST_READ  = 9'h001,
    ST_C1    = 9'h002,
    ST_C2    = 9'h004,
    ST_E3    = 9'h008,
    ST_E4    = 9'h010,
    ST_E5    = 9'h020,
    ST_PAGE  = 9'h040,
    ST_ID    = 9'h080,
    ST_BUSY  = 9'h100
  } fcs_state_e;
endpackage

// ### hdl/fcs_lock_window.sv
// keyed write window guarding the security enable bit
`timescale 1ns/10ps
`default_nettype none
module fcs_lock_window (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic keyWr,
  input  wire logic dataWr,
  input  wire logic dataBit,
  output logic      secEnable
);
  logic [4:0] winCnt_reg;
  logic       secEnable_reg;

  // window opens on the key store, closes after use or timeout
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      winCnt_reg <= 5'h0;
    end else if (keyWr) begin
      winCnt_reg <= fcs_pkg::LOCK_WIN_CLKS;
    end else if (dataWr) begin
      winCnt_reg <= 5'h0;
    end else if (winCnt_reg != 5'h0) begin
      winCnt_reg <= winCnt_reg - 5'h1;
    end
  end

  // unkeyed stores are dropped silently, no error is flagged
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      secEnable_reg <= fcs_pkg::SEC_RESET;
    end else if (dataWr && winCnt_reg != 5'h0) begin
      secEnable_reg <= dataBit;
    end
  end

  assign secEnable = secEnable_reg;
endmodule
`default_nettype wire

// ### test/fcs_engine_model.sv
// behavioural model of the flash array and its program/erase engine
`timescale 1ns/10ps
`default_nettype none
module fcs_engine_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        opStart,
  input  wire logic [16:0] arrayRdAddr,
  input  wire logic [3:0]  protSet,
  input  wire logic        slow,
  input  wire logic        failMode,
  output logic      [31:0] arrayRdData,
  output logic      [3:0]  blockProtect,
  output logic             opDone,
  output logic             opFail
);
  logic       busy;
  logic [7:0] cnt;
  // array content tagged in the top byte so served reads are recognisable
  assign arrayRdData  = {8'hc3, 7'h00, arrayRdAddr};
  assign blockProtect = protSet;
  // engine runs a short or long fixed time, then reports done or fail once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy   <= 1'b0;
      cnt    <= 8'h00;
      opDone <= 1'b0;
      opFail <= 1'b0;
    end else begin
      opDone <= 1'b0;
      opFail <= 1'b0;
      if (opStart) begin
        busy <= 1'b1;
        cnt  <= slow ? 8'h60 : 8'h08;
      end else if (busy && cnt == 8'h00) begin
        busy   <= 1'b0;
        opDone <= 1'b1;
        opFail <= failMode;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/fcs_checker.sv
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module fcs_checker (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic       avs_waitrequest,
  input  wire logic [3:0] blockProtect,
  input  wire logic       opStart,
  input  wire logic [3:0] eraseMask,
  input  wire logic       opDone,
  input  wire logic       opFail,
  input  wire logic       readMode,
  input  wire logic       arraySettled
);
  logic busyReg;
  logic failReg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // shadow of the automatic operation; a failure is sticky until pin reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busyReg <= 1'b0;
      failReg <= 1'b0;
    end else begin
      if (opStart) busyReg <= 1'b1;
      else if (busyReg && opDone && !opFail) busyReg <= 1'b0;
      if (busyReg && opFail) failReg <= 1'b1;
    end
  end
  sequence doneOk;
    busyReg && opDone && !opFail;
  endsequence
  sequence reqWait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  start_pulse_a: assert property (opStart |=> !opStart)
    else $error("start pulse longer than one cycle");
  busy_ignore_a: assert property (busyReg |-> !opStart)
    else $error("operation started while busy");
  done_read_a: assert property (doneOk |=> readMode)
    else $error("no return to read mode after completion");
  fail_stuck_a: assert property (failReg |-> !readMode && !opStart)
    else $error("left busy after failed operation");
  settle_clear_a: assert property (doneOk |=> !arraySettled)
    else $error("settle flag not cleared on completion");
  protect_mask_a: assert property (opStart |-> (eraseMask & blockProtect) == 4'h0)
    else $error("protected block selected for erase");
  stat_bound_a: assert property (reqWait |-> ##[1:2] !avs_waitrequest)
    else $error("register access not answered in time");
  ans_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
endmodule
bind fcs_sequencer fcs_checker u_chk (
  .sys_clk        (sys_clk),
  .rstn           (rstn),
  .avs_read       (avs_read),
  .avs_write      (avs_write),
  .avs_waitrequest(avs_waitrequest),
  .blockProtect   (blockProtect),
  .opStart        (opStart),
  .eraseMask      (eraseMask),
  .opDone         (opDone),
  .opFail         (opFail),
  .readMode       (readMode),
  .arraySettled   (arraySettled)
);
`default_nettype wire

// ### test/tb_flash_command_sequencer.sv
// register and command sequence tests for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_flash_command_sequencer;
  localparam logic [31:0] IDC  = 32'h0000_3c3c; // arbitrary value
  localparam logic [31:0] LOCK = fcs_pkg::REG_BASE + 32'h10;
  localparam logic [31:0] STAT = fcs_pkg::REG_BASE + 32'h20;
  logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest, opStart, pgmWordValid;
  logic opDone, opFail, readMode, idMode, securityEnable, arraySettled, slow, failMode;
  logic [31:0] avs_address, avs_writedata, avs_readdata, arrayRdData, pgmWordData, q;
  logic [16:0] arrayRdAddr, opAddr, pgmWordAddr, lastAddr;
  logic [3:0]  avs_byteenable, blockProtect, eraseMask, protSet, lastMask;
  logic [1:0]  opKind, lastKind;
  int          error_cnt, cmp_count, startCnt, wordCnt;
  fcs_sequencer #(.ID_CODE(IDC)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .arrayRdAddr(arrayRdAddr), .arrayRdData(arrayRdData), .blockProtect(blockProtect),
    .opStart(opStart), .opKind(opKind), .opAddr(opAddr), .eraseMask(eraseMask),
    .pgmWordValid(pgmWordValid), .pgmWordAddr(pgmWordAddr), .pgmWordData(pgmWordData),
    .opDone(opDone), .opFail(opFail), .readMode(readMode), .idMode(idMode),
    .securityEnable(securityEnable), .arraySettled(arraySettled));
  fcs_engine_model u_eng (.sys_clk(sys_clk), .rstn(rstn), .opStart(opStart),
    .arrayRdAddr(arrayRdAddr), .protSet(protSet), .slow(slow), .failMode(failMode),
    .arrayRdData(arrayRdData), .blockProtect(blockProtect), .opDone(opDone),
    .opFail(opFail));
  // clock at 20 MHz
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // record what each started operation asked of the engine
  always @(posedge sys_clk) begin
    if (opStart === 1'b1) begin
      startCnt++;
      lastKind <= opKind;
      lastAddr <= opAddr;
      lastMask <= eraseMask;
    end
    if (pgmWordValid === 1'b1) begin
      chk("pgm data", pgmWordData, wordCnt);
      chk("pgm addr", pgmWordAddr, 32'h80 + 32'(4 * wordCnt));
      wordCnt++;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus cycle held until waitrequest is sampled low; no bound on the wait, answer expected on the third edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    chk("bus answer", n, 3);
  endtask
  task automatic cw(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, {16'h0000, a, 8'h00}, {24'h000000, d});
  endtask
  task automatic unlock();
    cw(8'h55, 8'haa);
    cw(8'haa, 8'h55);
  endtask
  task automatic erase_pre();
    unlock();
    cw(8'h55, 8'h80);
    unlock();
  endtask
  // poll ready, then keep off the array until it has settled
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      xfer(1'b0, STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b1 && n < 200);
    n = 0;
    while (arraySettled !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard, well beyond the few settle times the tests need
  initial begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {rstn, avs_read, avs_write, slow, failMode} = 5'h00;
    {avs_address, avs_writedata} = 64'h0;
    avs_byteenable = 4'hf;
    protSet = 4'h2;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    xfer(1'b0, STAT, 32'h0); chk("status", q, 32'h0002_0001);
    xfer(1'b0, LOCK, 32'h0); chk("lock", q, 32'h1);
    xfer(1'b0, fcs_pkg::REG_BASE + 32'h30, 32'h0); chk("unmapped", q, 32'h0);
    xfer(1'b1, LOCK, 32'h0); xfer(1'b0, LOCK, 32'h0); chk("unkeyed", q, 32'h1);
    xfer(1'b1, LOCK, fcs_pkg::LOCK_KEY);
    xfer(1'b1, LOCK, 32'h0); xfer(1'b0, LOCK, 32'h0); chk("keyed", q, 32'h0);
    chk("sec port", securityEnable, 1'b0);
    xfer(1'b1, LOCK, fcs_pkg::LOCK_KEY);
    repeat (20) @(posedge sys_clk);
    xfer(1'b1, LOCK, 32'h1); xfer(1'b0, LOCK, 32'h0); chk("late", q, 32'h0);
    // block 2 erase on a slow engine, with a software reset sent while busy
    slow <= 1'b1;
    wait_ready();
    erase_pre();
    xfer(1'b1, 32'h0001_0000, 32'h30);
    xfer(1'b0, STAT, 32'h0); chk("busy", q, 32'h0002_0000);
    chk("auto mode", readMode, 1'b0);
    xfer(1'b0, 32'h100, 32'h0); chk("array in auto", q, 32'h0);
    xfer(1'b1, 32'h0, 32'hf0); xfer(1'b0, STAT, 32'h0); chk("still busy", q[0], 1'b0);
    wait_ready();
    chk("block op", {startCnt[3:0], 2'h0, lastKind, lastMask}, 12'h124);
    chk("block addr", lastAddr, 17'h10000);
    chk("read mode", readMode, 1'b1);
    slow <= 1'b0;
    // erase of protected block 1 is refused
    erase_pre();
    xfer(1'b1, 32'h0000_8000, 32'h30);
    xfer(1'b0, STAT, 32'h0); chk("refused", q, 32'h0002_0001);
    chk("refused start", startCnt, 1);
    erase_pre();
    cw(8'h55, 8'h10);
    wait_ready();
    chk("chip op", {startCnt[3:0], 2'h0, lastKind, lastMask}, 12'h21d);
    unlock();
    cw(8'h55, 8'ha0);
    for (int i = 0; i < 32; i++) xfer(1'b1, 32'h80 + 32'(4 * i), 32'(i));
    wait_ready();
    chk("page words", wordCnt, 32);
    chk("page op", {startCnt[3:0], lastKind, lastAddr}, 23'h180080);
    // wrong cycles abort; the rest of the erase must not start anything
    unlock();
    cw(8'haa, 8'h66);
    cw(8'h55, 8'h80);
    unlock();
    cw(8'h55, 8'h10);
    @(posedge sys_clk);
    chk("aborted", {startCnt[3:0], 3'h0, readMode}, 8'h31);
    xfer(1'b1, 32'h0, 32'hf0);
    unlock(); xfer(1'b1, 32'h40, 32'hf0); cw(8'h55, 8'h90); @(posedge sys_clk);
    chk("read cmd", idMode, 1'b0);
    unlock(); cw(8'h55, 8'hf0); cw(8'h55, 8'h90); @(posedge sys_clk);
    chk("reset cmd", idMode, 1'b0);
    unlock(); cw(8'h55, 8'h90); @(posedge sys_clk);
    chk("id mode", idMode, 1'b1);
    xfer(1'b0, 32'h200, 32'h0); chk("id value", q, IDC);
    xfer(1'b1, 32'h0, 32'hf0);
    xfer(1'b0, 32'h200, 32'h0); chk("array read", q, 32'hc300_0200);
    chk("id left", idMode, 1'b0);
    // a failed operation stays busy until pin reset
    failMode <= 1'b1;
    erase_pre();
    xfer(1'b1, 32'h0, 32'h30);
    repeat (300) @(posedge sys_clk);
    xfer(1'b0, STAT, 32'h0); chk("stuck busy", q[0], 1'b0);
    rstn     <= 1'b0;
    failMode <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    xfer(1'b0, STAT, 32'h0); chk("ready again", q, 32'h0002_0001);
    final_report();
  end
endmodule
`default_nettype wire
